// ### core/mbc_defines.vh
`ifndef MBC_DEFINES_VH
`define MBC_DEFINES_VH

// bus widths: 19-bit address reaches 512K bytes, 8-bit data
`define MBC_ADDR_W 19
`define MBC_DATA_W 8

// cycle kinds requested by the core
`define MBC_KIND_FETCH 2'h0
`define MBC_KIND_READ 2'h1
`define MBC_KIND_WRITE 2'h2

// phase counter: two oscillator periods per state, three states per cycle
`define MBC_PH_W 3
`define MBC_PH_LAST 3'h5
`define MBC_PH_STEP 3'h1
`define MBC_PH_S1A 3'h0
`define MBC_PH_S1B 3'h1
`define MBC_PH_S2A 3'h2
`define MBC_PH_S2B 3'h3
`define MBC_PH_S3A 3'h4
`define MBC_PH_S3B 3'h5

// values the bus registers take in reset
`define MBC_ADDR_RST 19'h00000
`define MBC_DATA_RST 8'h00

// oscillator nominal rate in kHz, kept for reference only; the bench does not use it
`define MBC_OSC_KHZ 12200

`endif

// ### core/mbc_bus_cycle.v
`include "mbc_defines.vh"

// Summary of operation
// - each bus state lasts two oscillator periods, here two mclk edges.
// - fetch, read and write each take three states, first to third.
// - a fetch puts the program counter on the address lines in the first half of the first state.
// - a fetch drives storage select and read strobe low from the second half of the first state.
// - a fetch captures the opcode at the edge that ends the second state.
// - a fetch holds the opcode flag low from the first half of the first state into the third.
// - data reads and writes leave the opcode flag high.
// - a data read samples the data lines at the edge that ends the third state.
// - a write drives storage select low from the second half of the first state, store strobe from the second state.
// - a write drives the byte onto the data lines from the second half of the first state.
// - a write releases storage select and store strobe in the second half of the third state.
// - the written byte stays driven until just before the next first state.
// - the address is 19 bits wide and data moves over an 8-bit two-way bus.
module mbc_bus_cycle
(
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // core request side
   input wire reqValid,
   input wire [1:0] reqKind,
   input wire [`MBC_ADDR_W-1:0] reqAddr,
   input wire [`MBC_DATA_W-1:0] reqWrData,
   output wire reqReady,
   output reg rspValid,
   output reg [`MBC_DATA_W-1:0] rspData,
   // memory bus
   output reg [`MBC_ADDR_W-1:0] addrLines,
   input wire [`MBC_DATA_W-1:0] dataLinesIn,
   output reg [`MBC_DATA_W-1:0] dataLinesOut,
   output reg dataLinesOe_n,
   output reg storageSelect_n,
   output reg readStrobe_n,
   output reg storeStrobe_n,
   output reg opcodeCycleFlag_n
);

   // idle waits for a request; run steps through the six phases of one cycle
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   reg state_reg;
   reg state_next;
   reg [`MBC_PH_W-1:0] phase_reg;
   reg [`MBC_PH_W-1:0] phase_next;
   reg [1:0] kind_reg;
   reg [`MBC_DATA_W-1:0] wrData_reg;
   reg startCycle;
   reg endCycle;

   // phase decode shared by strobes and capture; idle never matches a phase
   function atPhase;
      input runState;
      input [`MBC_PH_W-1:0] phase;
      input [`MBC_PH_W-1:0] wanted;
      begin
         atPhase = runState && (phase == wanted);
      end
   endfunction

   // a write drives the data lines and the store strobe in place of the read strobe
   function isWrite;
      input [1:0] kind;
      begin
         isWrite = (kind == `MBC_KIND_WRITE);
      end
   endfunction

   // a new cycle may start only when idle or at the last phase, keeping back to back cycles
   assign reqReady = (state_reg == ST_IDLE) || (phase_reg == `MBC_PH_LAST);

   // sequencer: six mclk phases make the three states
   always @*
   begin
      state_next = state_reg;
      phase_next = phase_reg;
      startCycle = 1'b0;
      endCycle = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            // a request seen in idle starts its cycle on this very edge
            if (reqValid)
            begin
               startCycle = 1'b1;
               state_next = ST_RUN;
               phase_next = `MBC_PH_S1A;
            end
         end
         ST_RUN:
         begin
            // the last phase hands straight over to a waiting request, no idle gap
            if (phase_reg == `MBC_PH_LAST)
            begin
               endCycle = 1'b1;
               phase_next = `MBC_PH_S1A;
               if (reqValid)
                  startCycle = 1'b1;
               else
                  state_next = ST_IDLE;
            end
            else
               phase_next = phase_reg + `MBC_PH_STEP;
         end
         default:
         begin
            // unreachable with two states; parks in idle
            state_next = ST_IDLE;
            phase_next = `MBC_PH_S1A;
         end
      endcase
   end

   // no synchroniser on the data lines: the memory answers our own strobes on this clock,
   // and extra flops would push the capture past the edge that ends the state

   // state, address and write byte
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         phase_reg <= `MBC_PH_S1A;
         kind_reg <= `MBC_KIND_FETCH;
         wrData_reg <= `MBC_DATA_RST;
         addrLines <= `MBC_ADDR_RST;
      end
      else
      begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         // latched only at the start, so address and byte stand for the whole cycle
         if (startCycle)
         begin
            kind_reg <= reqKind;
            addrLines <= reqAddr;
            wrData_reg <= reqWrData;
         end
      end
   end

   // bus strobes; all outputs are registered so they move at state half boundaries
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         storageSelect_n <= 1'b1;
         readStrobe_n <= 1'b1;
         storeStrobe_n <= 1'b1;
         opcodeCycleFlag_n <= 1'b1;
         dataLinesOe_n <= 1'b1;
         dataLinesOut <= `MBC_DATA_RST;
      end
      else
      begin
         // opcode flag low through the first half of the third state, then back high
         if (startCycle)
            opcodeCycleFlag_n <= (reqKind != `MBC_KIND_FETCH);
         else if (atPhase(state_reg == ST_RUN, phase_reg, `MBC_PH_S3A))
            opcodeCycleFlag_n <= 1'b1;
         else if (endCycle)
            opcodeCycleFlag_n <= 1'b1;
         // second half of the first state: select, then read strobe or write data
         if (atPhase(state_reg == ST_RUN, phase_reg, `MBC_PH_S1A))
         begin
            storageSelect_n <= 1'b0;
            readStrobe_n <= isWrite(kind_reg);
            if (isWrite(kind_reg))
            begin
               dataLinesOut <= wrData_reg;
               dataLinesOe_n <= 1'b0;
            end
         end
         // store strobe waits for the second state so the byte settles first
         else if (atPhase(state_reg == ST_RUN, phase_reg, `MBC_PH_S1B))
            storeStrobe_n <= !isWrite(kind_reg);
         else if (atPhase(state_reg == ST_RUN, phase_reg, `MBC_PH_S3A))
         begin
            // release in the second half of the third state
            storageSelect_n <= 1'b1;
            readStrobe_n <= 1'b1;
            storeStrobe_n <= 1'b1;
         end
         // write byte stays until just before the next first state; a following write
         // drives it again one phase later, so the lines float only for that phase
         if (endCycle)
            dataLinesOe_n <= 1'b1;
      end
   end

   // read capture straight from the data lines: a fetch at the end of the second state,
   // a data read at the end of the third, which gives slower memories a whole state more
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rspValid <= 1'b0;
         rspData <= `MBC_DATA_RST;
      end
      else
      begin
         // one-cycle pulse; the byte itself stands until the next capture
         rspValid <= 1'b0;
         if (atPhase(state_reg == ST_RUN, phase_reg, `MBC_PH_S2B) &&
            kind_reg == `MBC_KIND_FETCH)
         begin
            rspData <= dataLinesIn;
            rspValid <= 1'b1;
         end
         else if (endCycle && kind_reg == `MBC_KIND_READ)
         begin
            rspData <= dataLinesIn;
            rspValid <= 1'b1;
         end
      end
   end

endmodule // mbc_bus_cycle

// ### test/mbc_bus_cycle_checker.sv
`include "mbc_defines.vh"
module mbc_bus_cycle_checker
(
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // core request side
   input wire reqValid,
   input wire [1:0] reqKind,
   input wire [18:0] reqAddr,
   input wire [7:0] reqWrData,
   input wire reqReady,
   input wire rspValid,
   // memory bus
   input wire [18:0] addrLines,
   input wire [7:0] dataLinesOut,
   input wire dataLinesOe_n,
   input wire storageSelect_n,
   input wire readStrobe_n,
   input wire storeStrobe_n,
   input wire opcodeCycleFlag_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // a request is taken when the core asks while the sequencer is free
   wire tk = reqValid && reqReady;
   wire f = tk && reqKind == `MBC_KIND_FETCH;
   wire rd = tk && reqKind == `MBC_KIND_READ;
   wire wr = tk && reqKind == `MBC_KIND_WRITE;
   // low through the first half of the third state, high in its second half
   property p_flag; f |=> !opcodeCycleFlag_n[*5] ##1 opcodeCycleFlag_n; endproperty
   a_flag: assert property (p_flag) else $error("opcode flag span wrong");
   property p_noflag; tk && !f |=> opcodeCycleFlag_n[*6]; endproperty
   a_noflag: assert property (p_noflag) else $error("opcode flag in data cycle");
   property p_addr; tk |=> addrLines == $past(reqAddr); endproperty
   a_addr: assert property (p_addr) else $error("address not driven");
   property p_rd;
      f || rd |=> storageSelect_n ##1 (!storageSelect_n && !readStrobe_n)[*4] ##1 storageSelect_n;
   endproperty
   a_rd: assert property (p_rd) else $error("read strobes wrong");
   // late skip: a previous read may still answer in the first state
   property p_fr; f |=> ##1 !rspValid[*3] ##1 rspValid; endproperty
   a_fr: assert property (p_fr) else $error("fetch capture moment");
   property p_rr; rd |=> ##1 !rspValid[*5] ##1 rspValid; endproperty
   a_rr: assert property (p_rr) else $error("read capture moment");
   property p_wr;
      wr |=> storeStrobe_n ##1 (!storageSelect_n && storeStrobe_n && !dataLinesOe_n
         && dataLinesOut == $past(reqWrData, 2)) ##1 !storeStrobe_n[*3]
         ##1 (storeStrobe_n && storageSelect_n && !dataLinesOe_n);
   endproperty
   a_wr: assert property (p_wr) else $error("write cycle shape");
   property p_len; tk |=> !reqReady[*5] ##1 reqReady; endproperty
   a_len: assert property (p_len) else $error("cycle length");
   property p_idle;
      reqReady |-> storageSelect_n && readStrobe_n && storeStrobe_n && opcodeCycleFlag_n;
   endproperty
   a_idle: assert property (p_idle) else $error("strobe active when idle");
   c_f: cover property (f);
   c_r: cover property (rd);
   c_w: cover property (wr);
endmodule // mbc_bus_cycle_checker
bind mbc_bus_cycle mbc_bus_cycle_checker i_chk (.mclk, .rst_n, .reqValid, .reqReady, .rspValid,
   .dataLinesOe_n, .storageSelect_n, .readStrobe_n, .storeStrobe_n, .opcodeCycleFlag_n,
   .reqKind, .reqAddr, .addrLines, .reqWrData, .dataLinesOut);

// ### test/mbc_mem_model.sv
module mbc_mem_model
(
   // clock
   input wire mclk,
   // strobes from the sequencer
   input wire storageSelect_n,
   input wire readStrobe_n,
   input wire storeStrobe_n,
   input wire dataLinesOe_n,
   // address and data
   input wire [18:0] addrLines,
   input wire [7:0] dataLinesOut,
   output logic [7:0] dataLinesIn = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   // released bus toggles every cycle so a sample one cycle late sees the byte inverted
   always @(posedge mclk)
   begin
      if (!storageSelect_n && !storeStrobe_n && !dataLinesOe_n)
         mem[addrLines[7:0]] <= dataLinesOut;
      dataLinesIn <= (!storageSelect_n && !readStrobe_n) ? mem[addrLines[7:0]] : ~dataLinesIn;
   end
endmodule // mbc_mem_model

// ### test/mbc_bus_cycle_tb.sv
`include "mbc_defines.vh"
module mbc_bus_cycle_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n = 1'b0, reqValid = 1'b0;
   logic [1:0] reqKind = 2'h0;
   logic [18:0] reqAddr = 19'h00000;
   logic [7:0] reqWrData = 8'h00;
   wire reqReady, rspValid, dataLinesOe_n, storageSelect_n, readStrobe_n, storeStrobe_n;
   wire opcodeCycleFlag_n;
   wire [7:0] rspData, dataLinesIn, dataLinesOut;
   wire [18:0] addrLines;
   int num_errors = 0;
   int comparisons = 0;
   mbc_bus_cycle i_dut (.mclk, .rst_n, .reqValid, .reqKind, .reqAddr, .reqWrData, .reqReady,
      .rspValid, .rspData, .addrLines, .dataLinesIn, .dataLinesOut, .dataLinesOe_n,
      .storageSelect_n, .readStrobe_n, .storeStrobe_n, .opcodeCycleFlag_n);
   mbc_mem_model i_mem (.mclk, .storageSelect_n, .readStrobe_n, .storeStrobe_n,
      .dataLinesOe_n, .addrLines, .dataLinesOut, .dataLinesIn);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_lvl(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %0t: levels %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // request stays up on return so back-to-back cycles need no gap
   task go(input logic [1:0] k, input logic [18:0] a, input logic [7:0] d);
      int n;
      reqValid = 1'b1;
      reqKind = k;
      reqAddr = a;
      reqWrData = d;
      n = 0;
      while (reqReady !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk_lvl({3'h0, reqReady}, 4'h1);
      @(posedge mclk);
      #1;
   endtask
   task get(input logic [1:0] k, input logic [18:0] a, input logic [7:0] exp);
      int n;
      go(k, a, 8'h00);
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 10)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk_lvl({3'h0, rspValid}, 4'h1);
      chk(rspData, exp);
   endtask
   task t_wr_rd;
      go(`MBC_KIND_WRITE, 19'h7FF12, 8'hA5);
      go(`MBC_KIND_WRITE, 19'h00034, 8'h5A);
      go(`MBC_KIND_WRITE, 19'h40056, 8'hC3);
      // the fetch queues behind the last write with the request still raised
      get(`MBC_KIND_FETCH, 19'h7FF12, 8'hA5);
      get(`MBC_KIND_READ, 19'h00034, 8'h5A);
      get(`MBC_KIND_FETCH, 19'h40056, 8'hC3);
   endtask
   task t_reset;
      go(`MBC_KIND_FETCH, 19'h00034, 8'h00);
      reqValid = 1'b0;
      @(posedge mclk);
      #1;
      rst_n = 1'b0;
      @(posedge mclk);
      #1;
      chk_lvl({storageSelect_n, readStrobe_n, storeStrobe_n, opcodeCycleFlag_n}, 4'hF);
      rst_n = 1'b1;
      get(`MBC_KIND_READ, 19'h7FF12, 8'hA5);
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // about 50 cycles expected; far more is a hang
   initial
   begin
      #100000;
      num_errors++;
      print_verdict;
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      t_wr_rd;
      t_reset;
      print_verdict;
   end
endmodule // mbc_bus_cycle_tb
